/* pkg/dmscp_params.svh */
`ifndef DMSCP_PARAMS_SVH
`define DMSCP_PARAMS_SVH

// Timing
`define DMSCP_CLK_PERIOD_NS 40
`define DMSCP_STALL_MS      35

// 4-wire frame bit counts (counter value before the sampling edge)
`define DMSCP_ADDR_LAST  5'h06
`define DMSCP_CMD_LAST   5'h07
`define DMSCP_DATA_FIRST 5'h08
`define DMSCP_FRAME_LAST 5'h0f
`define DMSCP_FRAME_END  5'h10

// 2-wire byte handling
`define DMSCP_BYTE_BITS 4'h8
`define DMSCP_HS_CODE   5'h01
`define DMSCP_ALT_STEP  7'h01
`define DMSCP_ALT_PAGE  2'h1

// Page control register
`define DMSCP_PAGE_MSB   2
`define DMSCP_AUTO_PAGE_RETURN_BIT 7
`define DMSCP_PAGE_MASK  8'hc7
`define DMSCP_PAGE_RESET 8'h00

// Supported register ranges (page bits above the 7-bit address)
`define DMSCP_R0_LO 10'h050
`define DMSCP_R0_HI 10'h067
`define DMSCP_R1_LO 10'h0d0
`define DMSCP_R1_HI 10'h0df
`define DMSCP_R2_LO 10'h140
`define DMSCP_R2_HI 10'h14f
`define DMSCP_R3_LO 10'h200
`define DMSCP_R3_HI 10'h27f

`endif

/* pkg/dmscp_pkg.sv */
package dmscp_pkg;

  typedef enum logic [2:0] {
    TW_IDLE,
    TW_DEV,
    TW_REG,
    TW_WR,
    TW_RD
  } dmscp_tw_state_e;

endpackage : dmscp_pkg

/* hw/dmscp_sync_edge.sv */
`timescale 1ns/100ps
module dmscp_sync_edge #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] stage;
  logic [W-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[i]  <= 1'b0;
          stage[i] <= 1'b0;
          prev[i]  <= 1'b0;
        end else begin
          meta[i]  <= din[i];
          stage[i] <= meta[i];
          prev[i]  <= stage[i];
        end
      end
      assign level[i] = stage[i];
      assign rise[i]  = stage[i] & ~prev[i];
      assign fall[i]  = ~stage[i] & prev[i];
    end
  endgenerate

endmodule : dmscp_sync_edge

/* hw/dmscp_port.sv */
`timescale 1ns/100ps
`include "dmscp_params.svh"
// Overview of operation
// - 4-wire frame is 16 host clocks: command byte then data byte, no stretching.
// - First seven command bits are the register address, decoded after bit seven.
// - Eighth bit with direction polarity control selects read or write.
// - Write: host sends eight data bits; read: device shifts register out.
// - Address and data travel most significant bit first in both modes.
// - Chip select level set by polarity bit; inactive select resets interface.
// - Serial output high impedance except during data half of read frames.
// - Sample on rising edge when polarities match, else falling; output opposite.
// - 2-wire mode answers configurable write and read slave addresses; pins freed.
// - Address pick enable chooses first or second base address by input level.
// - 2-wire slave follows host clock, never holds clock low or arbitrates.
// - With timeout enabled, 2-wire interface resets after 35 ms without clock edges.
// - Master code 00001xxx at transfer start enters high speed for that transfer.
// - Continuous high speed control keeps high speed without master code.
// - Device is slave only and never starts transfers or drives START.
// - 2-wire reaches all eight pages (page bits 2:1 plus pointer bit 7); page register at address zero, optional auto_page_return.
// - Base address plus one reaches pages 2 and 3 directly.
// - 2-wire data in bytes; START and STOP are SDA edges while SCL high.
// - Device acknowledges own slave address, a supported register byte and each write data byte.
// - Unsupported register addresses ignored: no acknowledge, or output stays off.
// - Consecutive 2-wire accesses auto-increment pointer; missing registers read zero.
// - STOP inside a message returns the 2-wire interface to idle; START restarts at the slave address.
module dmscp_port #(
  parameter int STALL_CYCLES = `DMSCP_STALL_MS * 1000000 / `DMSCP_CLK_PERIOD_NS
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       interfaceTwoWire,
  input  wire logic       chipSelectPolarity,
  input  wire logic       directionBitPolarity,
  input  wire logic       clockPolarity,
  input  wire logic       clockPhase,
  input  wire logic [7:0] firstSlaveAddress,
  input  wire logic [7:0] secondSlaveAddress,
  input  wire logic       addressPickEnable,
  input  wire logic       clockStallTimeoutEnable,
  input  wire logic       continuousHighSpeed,
  input  wire logic       serialClockPin,
  input  wire logic       chipSelectLine,
  input  wire logic       serialInput,
  output logic            serialInputOut,
  output logic            serialInputOe,
  output logic            serialOutput,
  output logic            serialOutputOe,
  input  wire logic       addressPickLevel,
  output logic      [9:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdData,
  output logic      [2:0] activePage,
  output logic            highSpeedActive,
  output logic            sharedPinsFree
);

  logic [3:0] syncLvl;
  logic [3:0] syncRise;
  logic [3:0] syncFall;

  dmscp_sync_edge #(.W(4)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .din   ({addressPickLevel, chipSelectLine, serialInput, serialClockPin}),
    .level (syncLvl),
    .rise  (syncRise),
    .fall  (syncFall)
  );

  wire sck     = syncLvl[0];
  wire sckRise = syncRise[0];
  wire sckFall = syncFall[0];
  wire sdi     = syncLvl[1];
  wire sdiRise = syncRise[1];
  wire sdiFall = syncFall[1];
  wire csLvl   = syncLvl[2];
  wire pickLvl = syncLvl[3];

  logic [7:0]                    pageReg;
  logic                          pageUsed;
  logic [4:0]                    fwCnt;
  logic [7:0]                    fwShift;
  logic [6:0]                    fwAddr;
  logic                          fwRead;
  logic                          fwHit;
  logic                          csActiveD;
  logic [7:0]                    txShift;
  logic                          rdLoad;
  logic                          ldPage;
  logic                          ldHit;
  dmscp_pkg::dmscp_tw_state_e    twState;
  logic [3:0]                    twCnt;
  logic [7:0]                    twShift;
  logic [7:0]                    twPtr;
  logic                          twAck;
  logic                          twOe;
  logic                          twAlt;
  logic                          twMack;
  logic                          hsActive;
  logic [19:0]                   stallCnt;

  // Page register at address zero of each page, or a supported range
  function automatic logic regHit(input logic [9:0] a);
    regHit = (a[6:0] == 7'h00)
          || (a >= `DMSCP_R0_LO && a <= `DMSCP_R0_HI)
          || (a >= `DMSCP_R1_LO && a <= `DMSCP_R1_HI)
          || (a >= `DMSCP_R2_LO && a <= `DMSCP_R2_HI)
          || (a >= `DMSCP_R3_LO && a <= `DMSCP_R3_HI);
  endfunction : regHit

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // 4-wire side
  wire csActive     = !interfaceTwoWire && (csLvl == chipSelectPolarity);
  wire sampleOnRise = (clockPolarity == clockPhase);
  wire sampleEdge   = csActive && (sampleOnRise ? sckRise : sckFall);
  wire shiftEdge    = csActive && (sampleOnRise ? sckFall : sckRise);
  wire [9:0] fwFull = {pageReg[`DMSCP_PAGE_MSB:0], fwAddr};
  wire fwRdReq = sampleEdge && fwCnt == `DMSCP_CMD_LAST && (sdi ^ directionBitPolarity);
  wire fwWrReq = sampleEdge && fwCnt == `DMSCP_FRAME_LAST && !fwRead;
  wire fwDrive = shiftEdge && fwRead && fwHit
              && fwCnt >= `DMSCP_DATA_FIRST && fwCnt <= `DMSCP_FRAME_LAST;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwCnt          <= 5'h00;
      fwShift        <= 8'h00;
      fwAddr         <= 7'h00;
      fwRead         <= 1'b0;
      fwHit          <= 1'b0;
      csActiveD      <= 1'b0;
      serialOutput   <= 1'b0;
      serialOutputOe <= 1'b0;
    end else begin
      csActiveD <= csActive;
      if (!csActive) begin
        fwCnt          <= 5'h00;
        serialOutputOe <= 1'b0;
      end else begin
        if (sampleEdge) begin
          fwShift <= {fwShift[6:0], sdi};
          if (fwCnt != `DMSCP_FRAME_END) begin
            fwCnt <= fwCnt + 5'h01;
          end
          if (fwCnt == `DMSCP_ADDR_LAST) begin
            fwAddr <= {fwShift[5:0], sdi};
          end
          if (fwCnt == `DMSCP_CMD_LAST) begin
            fwRead <= sdi ^ directionBitPolarity;
            fwHit  <= regHit(fwFull);
          end
        end
        if (shiftEdge) begin
          serialOutputOe <= fwDrive;
          if (fwDrive) begin
            serialOutput <= txShift[7];
          end
        end
      end
    end
  end

  a_so_off_idle: assert property (!csActive |=> !serialOutputOe)
    else $error("serial output driven while chip select inactive");
  a_so_read_only: assert property (serialOutputOe |-> fwRead && fwHit && fwCnt >= 5'h08)
    else $error("serial output driven outside read data half");
  a_dir_polarity: assert property (sampleEdge && fwCnt == 5'h07
                                   |=> fwRead == ($past(sdi) ^ $past(directionBitPolarity)))
    else $error("direction bit not combined with polarity");

  sequence s_write_cmd;
    sampleEdge && fwCnt == 5'h07 && !(sdi ^ directionBitPolarity);
  endsequence
  sequence s_write_data_end;
    sampleEdge && fwCnt == 5'h0f && !fwRead && fwHit && fwAddr != 7'h00 && pageReg[2] == 1'b0;
  endsequence
  a_fw_write: assert property (s_write_cmd ##1 (!sampleEdge)[*1] ##[1:600] s_write_data_end
                               |=> regWrite && regWrData == {$past(fwShift[6:0]), $past(sdi)})
    else $error("4-wire write not issued with shifted data");

  // 2-wire side
  wire twOn      = interfaceTwoWire;
  wire startCond = twOn && sck && sdiFall;
  wire stopCond  = twOn && sck && sdiRise;
  wire [7:0] baseAddr = (addressPickEnable && !pickLvl) ? secondSlaveAddress
                                                        : firstSlaveAddress;
  wire matchBase = twShift[7:1] == baseAddr[7:1];
  wire matchAlt  = twShift[7:1] == baseAddr[7:1] + `DMSCP_ALT_STEP;
  wire hsCode    = twShift[7:3] == `DMSCP_HS_CODE;
  wire twActive  = twOn && twState != dmscp_pkg::TW_IDLE;
  wire twByteEnd = twActive && sckFall && !twAck && twCnt == `DMSCP_BYTE_BITS;
  wire devHit    = twState == dmscp_pkg::TW_DEV && !hsCode && (matchBase || matchAlt);
  wire twAltNow  = (twState == dmscp_pkg::TW_DEV) ? matchAlt : twAlt;
  wire [7:0] twPtrNow = (twState == dmscp_pkg::TW_REG) ? twShift : twPtr;
  wire [9:0] twFull = twAltNow ? {`DMSCP_ALT_PAGE, twPtrNow}
                               : {pageReg[`DMSCP_PAGE_MSB:1], twPtrNow};
  wire twRdReq = (twByteEnd && devHit && twShift[0])
              || (twActive && sckRise && twAck && twState == dmscp_pkg::TW_RD && !sdi);
  wire twWrReq = twByteEnd && twState == dmscp_pkg::TW_WR;
  wire twDrive = twActive && sckFall && twState == dmscp_pkg::TW_RD
              && (twAck ? twMack : twCnt < `DMSCP_BYTE_BITS);
  wire stallHit = clockStallTimeoutEnable && twActive
               && stallCnt >= 20'(STALL_CYCLES - 1);

  // The device only ever pulls the data line low and never touches the clock
  assign serialInputOut = 1'b0;
  assign serialInputOe  = twOe;
  assign sharedPinsFree = interfaceTwoWire;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      twState <= dmscp_pkg::TW_IDLE;
      twCnt   <= 4'h0;
      twShift <= 8'h00;
      twPtr   <= 8'h00;
      twAck   <= 1'b0;
      twOe    <= 1'b0;
      twAlt   <= 1'b0;
      twMack  <= 1'b0;
    end else if (startCond) begin
      twState <= dmscp_pkg::TW_DEV;
      twCnt   <= 4'h0;
      twAck   <= 1'b0;
      twOe    <= 1'b0;
    end else if (!twOn || stopCond || stallHit) begin
      twState <= dmscp_pkg::TW_IDLE;
      twAck   <= 1'b0;
      twOe    <= 1'b0;
    end else if (twActive && sckRise) begin
      if (twAck) begin
        twMack <= !sdi;
      end else if (twCnt < `DMSCP_BYTE_BITS) begin
        twShift <= {twShift[6:0], sdi};
        twCnt   <= twCnt + 4'h1;
      end
    end else if (twActive && sckFall) begin
      if (twAck) begin
        twAck <= 1'b0;
        twCnt <= 4'h0;
        twOe  <= twDrive && !txShift[7];
        if (twState == dmscp_pkg::TW_RD && !twMack) begin
          twState <= dmscp_pkg::TW_IDLE;
        end
      end else if (twCnt == `DMSCP_BYTE_BITS) begin
        twAck <= 1'b1;
        twOe  <= 1'b0;
        case (twState)
          dmscp_pkg::TW_DEV: begin
            twOe  <= devHit;
            twAlt <= matchAlt;
            if (!devHit) begin
              twState <= dmscp_pkg::TW_IDLE;
            end else if (twShift[0]) begin
              twState <= dmscp_pkg::TW_RD;
            end else begin
              twState <= dmscp_pkg::TW_REG;
            end
          end
          dmscp_pkg::TW_REG: begin
            twPtr <= twShift;
            twOe  <= regHit(twFull);
            twState <= regHit(twFull) ? dmscp_pkg::TW_WR : dmscp_pkg::TW_IDLE;
          end
          dmscp_pkg::TW_WR: begin
            twOe  <= 1'b1;
            twPtr <= twPtr + 8'h01;
          end
          dmscp_pkg::TW_RD: begin
            twPtr <= twPtr + 8'h01;
          end
          default: begin
            twState <= dmscp_pkg::TW_IDLE;
          end
        endcase
      end else begin
        twOe <= twDrive && !txShift[7];
      end
    end
  end

  sequence s_own_address;
    twByteEnd && devHit;
  endsequence
  a_addr_ack: assert property (s_own_address |=> serialInputOe && twAck)
    else $error("own slave address not acknowledged");
  a_bad_reg_nack: assert property (twByteEnd && twState == dmscp_pkg::TW_REG && !regHit(twFull)
                                   |=> !serialInputOe && twState == dmscp_pkg::TW_IDLE)
    else $error("unsupported register address acknowledged");
  a_stop_idle: assert property (stopCond && !startCond
                                |=> twState == dmscp_pkg::TW_IDLE && !serialInputOe)
    else $error("stop did not return interface to idle");
  a_sda_clock_low: assert property ($rose(serialInputOe) |-> !sck)
    else $error("data line pulled while clock high");

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stallCnt <= 20'h00000;
    end else if (!twActive || sckRise || sckFall) begin
      stallCnt <= 20'h00000;
    end else if (stallCnt != 20'hfffff) begin
      stallCnt <= stallCnt + 20'h00001;
    end
  end

  a_stall_reset: assert property (clockStallTimeoutEnable && twActive && !sckRise && !sckFall
                                  && stallCnt == 20'(STALL_CYCLES - 1) && !startCond
                                  |=> twState == dmscp_pkg::TW_IDLE)
    else $error("clock stall did not reset the interface");

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hsActive <= 1'b0;
    end else if (!twOn || stopCond || stallHit) begin
      hsActive <= 1'b0;
    end else if (twByteEnd && twState == dmscp_pkg::TW_DEV && hsCode) begin
      hsActive <= 1'b1;
    end
  end

  assign highSpeedActive = hsActive || continuousHighSpeed;

  a_hs_code: assert property (twByteEnd && twState == dmscp_pkg::TW_DEV && hsCode
                              |=> highSpeedActive && !serialInputOe)
    else $error("master code did not enter high speed");
  a_hs_cont: assert property (continuousHighSpeed |-> highSpeedActive)
    else $error("continuous high speed not applied");

  // Shared register request path
  wire       rdReq    = twOn ? twRdReq : fwRdReq;
  wire       wrReq    = twOn ? twWrReq : fwWrReq;
  wire [9:0] reqAddr  = twOn ? twFull : fwFull;
  wire [7:0] reqData  = twOn ? twShift : {fwShift[6:0], sdi};
  wire       reqPage  = reqAddr[6:0] == 7'h00;
  wire       reqHit   = regHit(reqAddr);
  wire       reqRo    = reqAddr >= `DMSCP_R3_LO;
  wire       frameEnd = (csActiveD && !csActive) || stopCond || stallHit;

  assign activePage = pageReg[`DMSCP_PAGE_MSB:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regAddr   <= 10'h000;
      regWrData <= 8'h00;
      regWrite  <= 1'b0;
      regRead   <= 1'b0;
      rdLoad    <= 1'b0;
      ldPage    <= 1'b0;
      ldHit     <= 1'b0;
      pageReg   <= `DMSCP_PAGE_RESET;
      pageUsed  <= 1'b0;
    end else begin
      regWrite <= wrReq && reqHit && !reqPage && !reqRo;
      regRead  <= rdReq && reqHit && !reqPage;
      rdLoad   <= rdReq;
      if (rdReq || wrReq) begin
        regAddr   <= reqAddr;
        regWrData <= reqData;
        ldPage    <= reqPage;
        ldHit     <= reqHit;
      end
      if (wrReq && reqPage) begin
        pageReg <= reqData & `DMSCP_PAGE_MASK;
      end else if (frameEnd && pageUsed && pageReg[`DMSCP_AUTO_PAGE_RETURN_BIT]) begin
        pageReg[`DMSCP_PAGE_MSB:0] <= 3'h0;
      end
      if (frameEnd) begin
        pageUsed <= 1'b0;
      end else if ((rdReq || wrReq) && !reqPage) begin
        pageUsed <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txShift <= 8'h00;
    end else if (rdLoad) begin
      txShift <= ldPage ? pageReg : (ldHit ? regRdData : 8'h00);
    end else if (fwDrive || twDrive) begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  a_page_auto_page_return: assert property (frameEnd && pageUsed && pageReg[7] && !(wrReq && reqPage)
                                  |=> activePage == 3'h0)
    else $error("page did not auto_page_return to zero");
  a_missing_zero: assert property (rdLoad && !ldHit |=> txShift == 8'h00)
    else $error("missing register did not read as zero");

endmodule : dmscp_port

/* verif/dmscp_host_model.sv */
`timescale 1ns/100ps
module dmscp_host_model (
  output logic     sk,
  output logic     cs,
  output logic     si,
  input  wire logic so,
  input  wire logic sda
);
  localparam time H = 160ns;

  initial begin
    sk = 1'b0;
    cs = 1'b1;
    si = 1'b1;
  end

  task automatic idle(input logic csLvl, input logic skLvl);
    cs = csLvl;
    sk = skLvl;
    si = 1'b1;
    #(2*H);
  endtask : idle

  // SO is taken just before the next shift edge, while the device still holds it
  task automatic frame(input logic cpha, input logic csAct, input logic rd,
                       input logic [15:0] word, input int n, output logic [7:0] got);
    got = 8'h00;
    cs = csAct;
    #H;
    for (int i = 0; i < n; i++) begin
      if (cpha) sk = ~sk;
      si = (rd && i > 7) ? ~si : word[15-i];
      #H;
      sk = ~sk;
      #H;
      if (i > 7) got = {got[6:0], so};
      if (!cpha) sk = ~sk;
    end
    #H;
    cs = ~csAct;
    si = ~si;
    #(2*H);
  endtask : frame

  task automatic start2();
    #(H/2);
    si = 1'b1;
    #(H/2);
    sk = 1'b1;
    #H;
    si = 1'b0;
    #H;
  endtask : start2

  task automatic stop2();
    #(H/2);
    si = 1'b0;
    #(H/2);
    sk = 1'b1;
    #H;
    si = 1'b1;
    #H;
  endtask : stop2

  // Ninth bit is always released, so a read byte ends with a not-acknowledge
  task automatic byte2(input logic [7:0] b, output logic ack, output logic [7:0] got);
    for (int i = 7; i >= -1; i--) begin
      sk = 1'b0;
      #(H/2);
      si = (i < 0) ? 1'b1 : b[i];
      #(H/2);
      sk = 1'b1;
      #H;
      if (i >= 0) got = {got[6:0], sda};
      ack = ~sda;
    end
    sk = 1'b0;
  endtask : byte2
endmodule : dmscp_host_model

/* verif/tb_dual_mode_serial_control_port.sv */
`timescale 1ns/100ps
module tb_dual_mode_serial_control_port;
  logic       clk     = 1'b0;
  logic       rst     = 1'b1;
  logic       twoWire = 1'b0;
  logic       csPol   = 1'b0;
  logic       dirPol  = 1'b0;
  logic       cpol    = 1'b0;
  logic       cpha    = 1'b0;
  logic       hsCont  = 1'b0;
  logic       oeOk    = 1'b0;
  logic       pickEn  = 1'b0;
  logic       pickLvl = 1'b1;
  logic       sk, cs, si, sdaOe, soData, soOe, regWrite, regRead, hsAct, pinsFree;
  logic [9:0] regAddr;
  logic [9:0] wrAddr;
  logic [7:0] regWrData;
  logic [7:0] wrData;
  logic [2:0] page;
  int         wrCnt = 0, rdCnt = 0, badOe = 0, errors = 0, checkCount = 0;
  wire logic  sdaLine = si & ~sdaOe;
  wire logic  soLine  = soOe ? soData : 1'b1;

  function automatic logic [7:0] rdFn(input logic [9:0] a);
    return a[7:0] ^ 8'h3c ^ {6'h00, a[9:8]};
  endfunction : rdFn

  always #20 clk = ~clk;

  dmscp_port #(.STALL_CYCLES(200)) dmscp_port_i (
    .clk(clk), .rst(rst), .interfaceTwoWire(twoWire), .chipSelectPolarity(csPol),
    .directionBitPolarity(dirPol), .clockPolarity(cpol), .clockPhase(cpha),
    .firstSlaveAddress(8'hd0), .secondSlaveAddress(8'he0), .addressPickEnable(pickEn),
    .clockStallTimeoutEnable(1'b1), .continuousHighSpeed(hsCont), .serialClockPin(sk),
    .chipSelectLine(cs), .serialInput(twoWire ? sdaLine : si), .serialInputOut(),
    .serialInputOe(sdaOe), .serialOutput(soData), .serialOutputOe(soOe),
    .addressPickLevel(pickLvl), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(rdFn(regAddr)),
    .activePage(page), .highSpeedActive(hsAct), .sharedPinsFree(pinsFree));

  dmscp_host_model dmscp_host_model_i (.sk(sk), .cs(cs), .si(si), .so(soLine), .sda(sdaLine));

  always @(posedge clk) begin
    if (regWrite) begin
      wrCnt <= wrCnt + 1;
      wrAddr <= regAddr;
      wrData <= regWrData;
    end
    if (soOe && !oeOk) badOe <= badOe + 1;
    if (regRead) rdCnt <= rdCnt + 1;
  end

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    $display("Checks %0d, mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finishTest

  task automatic xfer4(input logic rd, input logic [6:0] a, input logic [7:0] d, input int n,
                       output logic [7:0] got);
    dmscp_host_model_i.frame(cpha, csPol, rd, {a, rd ^ dirPol, d}, n, got);
  endtask : xfer4

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    finishTest();
  end

  initial begin
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] got;
    logic [7:0] slv [3];
    logic [7:0] rg [3];
    logic       ack;
    int         w0, r0;
    slv = '{8'hd4, 8'hd0, 8'hd2};
    rg = '{8'h55, 8'h10, 8'h45};
    void'($urandom(32'h62af87c2));
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    for (int m = 0; m < 8; m++) begin
      dmscp_host_model_i.idle(~m[2], m[1]);
      @(posedge clk);
      #1;
      {csPol, cpol, cpha} = m[2:0];
      dirPol = 1'($urandom);
      a = 7'h50 + 7'($urandom % 24);
      d = 8'($urandom);
      w0 = wrCnt;
      xfer4(1'b0, a, d, 16, got);
      check("write count", 10'(wrCnt - w0), 10'h001);
      check("write addr", wrAddr, {3'h0, a});
      check("write data", {2'h0, wrData}, {2'h0, d});
      oeOk = 1'b1;
      xfer4(1'b1, 7'h00, 8'h00, 16, got);
      check("page idle", {2'h0, got}, 10'h000);
      r0 = rdCnt;
      xfer4(1'b1, a, 8'h00, 16, got);
      oeOk = 1'b0;
      check("read data", {2'h0, got}, {2'h0, rdFn({3'h0, a})});
      a = 7'h01 + 7'($urandom % 79);
      w0 = wrCnt;
      xfer4(1'b0, a, d, 16, got);
      xfer4(1'b1, a, d, 16, got);
      check("unmapped read", {2'h0, got}, 10'h0ff);
      check("read count", 10'(rdCnt - r0), 10'h001);
      xfer4(1'b0, 7'h55, d, 10, got);
      check("ignored writes", 10'(wrCnt - w0), 10'h000);
    end
    xfer4(1'b0, 7'h00, 8'h81, 16, got);
    check("page", {7'h00, page}, 10'h001);
    oeOk = 1'b1;
    xfer4(1'b1, 7'h00, 8'h00, 16, got);
    check("page read", {2'h0, got}, 10'h081);
    xfer4(1'b1, 7'h55, 8'h00, 16, got);
    check("paged read", {2'h0, got}, {2'h0, rdFn(10'h0d5)});
    check("page auto_page_return", {7'h00, page}, 10'h000);
    xfer4(1'b0, 7'h00, 8'h00, 16, got);
    xfer4(1'b1, 7'h00, 8'h00, 16, got);
    oeOk = 1'b0;
    check("page clear", {2'h0, got}, 10'h000);
    @(posedge clk);
    #1 twoWire = 1'b1;
    dmscp_host_model_i.idle(1'b1, 1'b1);
    check("pins free", {9'h0, pinsFree}, 10'h001);
    a = 7'h50 + 7'($urandom % 22);
    w0 = wrCnt;
    dmscp_host_model_i.start2();
    dmscp_host_model_i.byte2(8'hd0, ack, got);
    check("slave ack", {9'h0, ack}, 10'h001);
    dmscp_host_model_i.byte2({1'b0, a}, ack, got);
    check("reg ack", {9'h0, ack}, 10'h001);
    dmscp_host_model_i.byte2(d, ack, got);
    dmscp_host_model_i.byte2(~d, ack, got);
    check("data ack", {9'h0, ack}, 10'h001);
    dmscp_host_model_i.stop2();
    check("burst count", 10'(wrCnt - w0), 10'h002);
    check("burst addr", wrAddr, {3'h0, a + 7'h01});
    check("burst data", {2'h0, wrData}, {2'h0, ~d});
    dmscp_host_model_i.start2();
    dmscp_host_model_i.byte2(8'hd0, ack, got);
    dmscp_host_model_i.byte2({1'b0, a}, ack, got);
    dmscp_host_model_i.start2();
    dmscp_host_model_i.byte2(8'hd1, ack, got);
    dmscp_host_model_i.byte2(8'hff, ack, got);
    dmscp_host_model_i.stop2();
    check("2-wire read", {2'h0, got}, {2'h0, rdFn({3'h0, a})});
    w0 = wrCnt;
    for (int i = 0; i < 3; i++) begin
      dmscp_host_model_i.start2();
      dmscp_host_model_i.byte2(slv[i], ack, got);
      check("slave match", {9'h0, ack}, {9'h0, i != 0});
      dmscp_host_model_i.byte2(rg[i], ack, got);
      check("reg range", {9'h0, ack}, {9'h0, i == 2});
      dmscp_host_model_i.byte2(d, ack, got);
      dmscp_host_model_i.stop2();
    end
    check("alt count", 10'(wrCnt - w0), 10'h001);
    check("alt addr", wrAddr, 10'h145);
    @(posedge clk);
    #1 {pickEn, pickLvl} = 2'b10;
    for (int i = 0; i < 2; i++) begin
      dmscp_host_model_i.start2();
      dmscp_host_model_i.byte2(i ? 8'he0 : 8'hd0, ack, got);
      check("pick addr", {9'h0, ack}, {9'h0, i == 1});
      dmscp_host_model_i.stop2();
    end
    @(posedge clk);
    #1 {pickEn, pickLvl} = 2'b01;
    dmscp_host_model_i.start2();
    dmscp_host_model_i.byte2(8'h08, ack, got);
    check("code ack", {9'h0, ack}, 10'h000);
    check("high speed", {9'h0, hsAct}, 10'h001);
    dmscp_host_model_i.stop2();
    check("high speed end", {9'h0, hsAct}, 10'h000);
    @(posedge clk);
    #1 hsCont = 1'b1;
    @(posedge clk);
    #1 check("continuous", {9'h0, hsAct}, 10'h001);
    hsCont = 1'b0;
    dmscp_host_model_i.start2();
    dmscp_host_model_i.byte2(8'hd0, ack, got);
    repeat (300) @(posedge clk);
    dmscp_host_model_i.byte2(8'h55, ack, got);
    check("stall reset", {9'h0, ack}, 10'h000);
    dmscp_host_model_i.stop2();
    check("so enable", 10'(badOe), 10'h000);
    finishTest();
  end
endmodule : tb_dual_mode_serial_control_port
